//--- rtl/dps_pkg.sv
// shared types, functions and spacing constants for the packet spacing scheduler
// assumes all spacing figures are counted in channel clock cycles
package dps_pkg;

  localparam int DEV_W = 2;
  localparam int BANK_W = 4;
  localparam int CNT_W = 8;
  localparam logic [BANK_W-1:0] BANK_LAST = 4'hF;

  // channel cycle length in CLK cycles
  localparam logic [CNT_W-1:0] TICK_DIV_DEF = 8'h01;

  // spacing figures in channel cycles
  localparam logic [CNT_W-1:0] OPEN_TO_COLUMN_DELAY = 8'h07;
  localparam logic [CNT_W-1:0] COLUMN_PACKET_SPACING = 8'h04;
  localparam logic [CNT_W-1:0] READ_DATA_LATENCY = 8'h08;
  localparam logic [CNT_W-1:0] READ_ADDED_DELAY = 8'h00;
  localparam logic [CNT_W-1:0] STORE_DATA_LATENCY = 8'h06;
  localparam logic [CNT_W-1:0] STORE_TO_RETIRE_DELAY = 8'h08;
  localparam logic [CNT_W-1:0] READ_TO_CLOSE_DELAY = 8'h04;
  localparam logic [CNT_W-1:0] RETIRE_TO_CLOSE_DELAY = 8'h04;
  localparam logic [CNT_W-1:0] ROW_PACKET_LENGTH = 8'h04;
  localparam logic [CNT_W-1:0] ROW_REPEAT_GAP = 8'h04;
  localparam logic [CNT_W-1:0] OPEN_TO_CLOSE_MIN = 8'h14;
  localparam logic [CNT_W-1:0] CLOSE_TO_OPEN_MIN = 8'h08;
  localparam logic [CNT_W-1:0] OPEN_TO_OPEN_MIN = 8'h1C;
  localparam logic [CNT_W-1:0] READ_TO_STORE_GAP =
    COLUMN_PACKET_SPACING + READ_DATA_LATENCY + READ_ADDED_DELAY - STORE_DATA_LATENCY;
  localparam logic [CNT_W-1:0] SINCE_MAX = 8'hFF;

  typedef enum logic [2:0] {
    row_idle_cmd = 3'h0,
    row_open_cmd = 3'h1,
    row_close_cmd = 3'h2,
    refresh_open_cmd = 3'h3,
    refresh_close_cmd = 3'h4
  } dps_row_op_t;

  typedef enum logic [2:0] {
    column_idle_cmd = 3'h0,
    column_read_cmd = 3'h1,
    column_store_cmd = 3'h2,
    column_close_cmd = 3'h3,
    read_then_close_cmd = 3'h4,
    store_then_close_cmd = 3'h5
  } dps_col_op_t;

  typedef enum logic [1:0] {
    cls_idle = 2'h0,
    cls_read = 2'h1,
    cls_store = 2'h2
  } dps_col_cls_t;

  typedef struct packed {
    dps_row_op_t op;
    logic [DEV_W-1:0] dev;
    logic [BANK_W-1:0] bank;
  } dps_row_pkt_t;

  typedef struct packed {
    dps_col_op_t op;
    logic [DEV_W-1:0] dev;
    logic [BANK_W-1:0] bank;
  } dps_col_pkt_t;

  typedef struct packed {
    dps_col_cls_t cls;
    logic [DEV_W-1:0] dev;
    logic [BANK_W-1:0] bank;
    logic unretired;
  } dps_col_hist_t;

  function automatic dps_col_cls_t col_class(dps_col_op_t op);
    case (op)
      column_read_cmd, read_then_close_cmd: col_class = cls_read;
      column_store_cmd, store_then_close_cmd: col_class = cls_store;
      default: col_class = cls_idle;
    endcase
  endfunction

  function automatic logic col_closes(dps_col_op_t op);
    col_closes = (op == column_close_cmd) || (op == read_then_close_cmd) ||
                 (op == store_then_close_cmd);
  endfunction

  function automatic logic row_opens(dps_row_op_t op);
    row_opens = (op == row_open_cmd) || (op == refresh_open_cmd);
  endfunction

  function automatic logic row_closes(dps_row_op_t op);
    row_closes = (op == row_close_cmd) || (op == refresh_close_cmd);
  endfunction

endpackage

//--- rtl/dps_gap_timer.sv
// channel cycles elapsed since the last event, saturating
// assumes tick is a one-cycle enable on the same clock
`timescale 1ns/1ps
module dps_gap_timer (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // event and count
  input wire logic tick,
  input wire logic hit,
  output logic [dps_pkg::CNT_W-1:0] since
);
  // starts saturated so the first packet is never held back
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      since <= dps_pkg::SINCE_MAX;
    end else if (hit) begin
      since <= 8'h01;
    end else if (tick && since != dps_pkg::SINCE_MAX) begin
      since <= since + 8'h01;
    end
  end
endmodule

//--- rtl/dps_row_col_sched.sv
// controller side scheduler placing row and column packets with legal spacing
// assumes requests come from logic on CLK; packets drive the device pins directly
`timescale 1ns/1ps
module dps_row_col_sched #(
  parameter logic [dps_pkg::CNT_W-1:0] TICK_DIV = dps_pkg::TICK_DIV_DEF
) (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // row requests
  input wire dps_pkg::dps_row_pkt_t ROW_REQ,
  input wire logic ROW_REQ_VALID,
  output logic ROW_REQ_READY,
  output logic ROW_REFUSED,
  // column requests
  input wire dps_pkg::dps_col_pkt_t COL_REQ,
  input wire logic COL_REQ_VALID,
  output logic COL_REQ_READY,
  output logic COL_REFUSED,
  // device pins
  output dps_pkg::dps_row_pkt_t ROW_PKT,
  output logic ROW_PKT_VALID,
  output dps_pkg::dps_col_pkt_t COL_PKT,
  output logic COL_PKT_VALID
);
  localparam int IDX_W = dps_pkg::DEV_W + dps_pkg::BANK_W;
  localparam int NENT = 2 ** IDX_W;
  localparam int NDEV = 2 ** dps_pkg::DEV_W;
  localparam int CW = dps_pkg::CNT_W;

  logic [CW-1:0] tick_cnt_reg;
  logic tick;
  logic [NENT-1:0] open_reg;
  logic [CW-1:0] open_ok_reg [NENT];
  logic [CW-1:0] close_ok_reg [NENT];
  logic [CW-1:0] col_ok_reg [NENT];
  logic [NDEV-1:0] wb_valid_reg;
  logic [dps_pkg::BANK_W-1:0] wb_bank_reg [NDEV];
  logic [CW-1:0] wb_age_reg [NDEV];
  dps_pkg::dps_col_hist_t hist1_reg, hist2_reg;
  dps_pkg::dps_row_pkt_t last_row_reg, row_pkt_reg;
  dps_pkg::dps_col_pkt_t col_pkt_reg, col_out;
  logic row_pkt_valid_reg, col_pkt_valid_reg;
  logic [CW-1:0] row_since, col_since, col_need;
  logic [IDX_W-1:0] ridx, cidx;
  logic r_open, r_close, row_legal, row_time_ok, same_kind, wb_hold, row_go;
  dps_pkg::dps_col_cls_t c_cls, o_cls;
  logic col_legal, col_time_ok, col_go_req, fill_go, col_go, retire_due;
  logic [NDEV-1:0] aged, retire;

  // channel cycle enable; every decision and count advances only on it
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_cnt_reg <= 8'h00;
    end else if (tick_cnt_reg >= TICK_DIV - 8'h01) begin
      tick_cnt_reg <= 8'h00;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
    end
  end
  assign tick = (tick_cnt_reg == 8'h00);

  function automatic logic adj_open(logic [dps_pkg::DEV_W-1:0] dev,
                                    logic [dps_pkg::BANK_W-1:0] bank);
    adj_open = (bank != 4'h0 && open_reg[{dev, bank - 4'h1}]) ||
               (bank != dps_pkg::BANK_LAST && open_reg[{dev, bank + 4'h1}]);
  endfunction

  // entry i is the bank itself or a sense-amp neighbour; no wrap past the ends
  function automatic logic near(int i, logic [dps_pkg::DEV_W-1:0] dev,
                                logic [dps_pkg::BANK_W-1:0] bank);
    logic [IDX_W-1:0] e;
    logic [dps_pkg::BANK_W-1:0] eb;
    e = IDX_W'(i);
    eb = e[dps_pkg::BANK_W-1:0];
    near = (e[IDX_W-1:dps_pkg::BANK_W] == dev) && ((eb == bank) ||
           (bank != dps_pkg::BANK_LAST && eb == bank + 4'h1) ||
           (bank != 4'h0 && eb == bank - 4'h1));
  endfunction

  // counts down to zero; a load keeps the larger of old and new wait
  function automatic logic [CW-1:0] bump(logic [CW-1:0] cur, logic en, logic [CW-1:0] val);
    bump = (en && (val - 8'h01) > cur) ? val - 8'h01 : cur;
  endfunction

  function automatic logic [CW-1:0] dec(logic [CW-1:0] cur);
    dec = (tick && cur != 8'h00) ? cur - 8'h01 : cur;
  endfunction

  function automatic logic [CW-1:0] need_gap(dps_pkg::dps_col_hist_t h2,
      dps_pkg::dps_col_hist_t h1, dps_pkg::dps_col_cls_t cls, logic [dps_pkg::DEV_W-1:0] dev);
    if (h1.cls == dps_pkg::cls_idle || cls == dps_pkg::cls_idle) begin
      need_gap = dps_pkg::COLUMN_PACKET_SPACING;
    end else if (h1.cls == dps_pkg::cls_read && cls == dps_pkg::cls_store) begin
      need_gap = dps_pkg::READ_TO_STORE_GAP;
    end else if (h1.cls == dps_pkg::cls_store && cls == dps_pkg::cls_read &&
                 dev == h1.dev && h2.dev == h1.dev &&
                 (h2.cls == dps_pkg::cls_store ||
                  (h2.cls == dps_pkg::cls_read && h2.unretired))) begin
      need_gap = dps_pkg::STORE_TO_RETIRE_DELAY;
    end else begin
      need_gap = dps_pkg::COLUMN_PACKET_SPACING;
    end
  endfunction

  // column side
  assign cidx = {COL_REQ.dev, COL_REQ.bank};
  assign c_cls = dps_pkg::col_class(COL_REQ.op);
  assign col_legal = (c_cls == dps_pkg::cls_idle) || open_reg[cidx];
  assign col_need = need_gap(hist2_reg, hist1_reg, c_cls, COL_REQ.dev);
  assign col_time_ok = (col_since >= col_need) &&
                       (c_cls == dps_pkg::cls_idle || col_ok_reg[cidx] == 8'h00);
  assign COL_REQ_READY = tick && (!col_legal || col_time_ok);
  assign COL_REFUSED = tick && COL_REQ_VALID && !col_legal;
  assign col_go_req = COL_REQ_READY && COL_REQ_VALID && col_legal;

  // an aged store retires only when some column packet follows; idle fills the slot
  always_comb begin
    for (int d = 0; d < NDEV; d++) begin
      aged[d] = wb_valid_reg[d] && (wb_age_reg[d] >= dps_pkg::STORE_TO_RETIRE_DELAY);
    end
  end
  assign retire_due = |aged;
  assign fill_go = tick && !col_go_req && retire_due &&
                   (col_since >= dps_pkg::COLUMN_PACKET_SPACING);
  assign col_go = col_go_req || fill_go;
  always_comb begin
    col_out = COL_REQ;
    if (!col_go_req) begin
      col_out.op = dps_pkg::column_idle_cmd;
      col_out.dev = '0;
      col_out.bank = '0;
    end
  end
  assign o_cls = dps_pkg::col_class(col_out.op);

  always_comb begin
    for (int d = 0; d < NDEV; d++) begin
      retire[d] = col_go && wb_valid_reg[d] &&
                  ((aged[d] && !(o_cls == dps_pkg::cls_read && col_out.dev == d)) ||
                   (o_cls == dps_pkg::cls_store && col_out.dev == d));
    end
  end

  // row side
  assign ridx = {ROW_REQ.dev, ROW_REQ.bank};
  assign r_open = dps_pkg::row_opens(ROW_REQ.op);
  assign r_close = dps_pkg::row_closes(ROW_REQ.op);
  assign wb_hold = wb_valid_reg[ROW_REQ.dev] && (wb_bank_reg[ROW_REQ.dev] == ROW_REQ.bank);
  assign same_kind = (last_row_reg.dev == ROW_REQ.dev) &&
                     ((dps_pkg::row_opens(last_row_reg.op) && r_open) ||
                      (dps_pkg::row_closes(last_row_reg.op) && r_close));
  always_comb begin
    if (r_open) begin
      row_legal = !open_reg[ridx] && !adj_open(ROW_REQ.dev, ROW_REQ.bank);
    end else if (r_close) begin
      row_legal = !adj_open(ROW_REQ.dev, ROW_REQ.bank);
    end else begin
      row_legal = 1'b1;
    end
  end
  always_comb begin
    row_time_ok = (row_since >= dps_pkg::ROW_PACKET_LENGTH) &&
                  (!same_kind || row_since >= dps_pkg::ROW_REPEAT_GAP);
    if (r_open) begin
      row_time_ok = row_time_ok && (open_ok_reg[ridx] == 8'h00);
    end else if (r_close) begin
      row_time_ok = row_time_ok && (close_ok_reg[ridx] == 8'h00) && !wb_hold;
    end
  end
  // a row and column packet to one device in one slot would race the bank state
  assign ROW_REQ_READY = tick && (!row_legal ||
                         (row_time_ok && !(col_go && col_out.dev == ROW_REQ.dev)));
  assign ROW_REFUSED = tick && ROW_REQ_VALID && !row_legal;
  assign row_go = ROW_REQ_READY && ROW_REQ_VALID && row_legal;

  dps_gap_timer u_row_gap (
    .clk(CLK),
    .arst_n(ARST_N),
    .tick(tick),
    .hit(row_go),
    .since(row_since)
  );

  dps_gap_timer u_col_gap (
    .clk(CLK),
    .arst_n(ARST_N),
    .tick(tick),
    .hit(col_go),
    .since(col_since)
  );

  // bank state
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      open_reg <= '0;
    end else begin
      if (row_go && r_open) open_reg[ridx] <= 1'b1;
      if (row_go && r_close) open_reg[ridx] <= 1'b0;
      if (col_go_req && dps_pkg::col_closes(COL_REQ.op)) open_reg[cidx] <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < NENT; i++) open_ok_reg[i] <= 8'h00;
    end else begin
      for (int i = 0; i < NENT; i++) begin
        open_ok_reg[i] <= bump(bump(bump(dec(open_ok_reg[i]),
          row_go && r_open && near(i, ROW_REQ.dev, ROW_REQ.bank),
          dps_pkg::OPEN_TO_OPEN_MIN),
          row_go && r_close && near(i, ROW_REQ.dev, ROW_REQ.bank),
          dps_pkg::CLOSE_TO_OPEN_MIN),
          col_go_req && dps_pkg::col_closes(COL_REQ.op) && near(i, COL_REQ.dev, COL_REQ.bank),
          dps_pkg::CLOSE_TO_OPEN_MIN);
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < NENT; i++) close_ok_reg[i] <= 8'h00;
    end else begin
      for (int i = 0; i < NENT; i++) begin
        close_ok_reg[i] <= bump(bump(bump(dec(close_ok_reg[i]),
          row_go && r_open && ridx == i, dps_pkg::OPEN_TO_CLOSE_MIN),
          col_go && o_cls == dps_pkg::cls_read && cidx == i,
          dps_pkg::READ_TO_CLOSE_DELAY),
          retire[i >> dps_pkg::BANK_W] &&
          wb_bank_reg[i >> dps_pkg::BANK_W] == (IDX_W'(i) & 6'h0F),
          dps_pkg::RETIRE_TO_CLOSE_DELAY);
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < NENT; i++) col_ok_reg[i] <= 8'h00;
    end else begin
      for (int i = 0; i < NENT; i++) begin
        col_ok_reg[i] <= bump(dec(col_ok_reg[i]), row_go && r_open && ridx == i,
                              dps_pkg::OPEN_TO_COLUMN_DELAY);
      end
    end
  end

  // write buffer, one per device
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wb_valid_reg <= '0;
      for (int d = 0; d < NDEV; d++) begin
        wb_bank_reg[d] <= 4'h0;
        wb_age_reg[d] <= 8'h00;
      end
    end else begin
      for (int d = 0; d < NDEV; d++) begin
        if (col_go && o_cls == dps_pkg::cls_store && col_out.dev == d) begin
          wb_valid_reg[d] <= 1'b1;
          wb_bank_reg[d] <= col_out.bank;
          wb_age_reg[d] <= 8'h01;
        end else begin
          if (retire[d]) wb_valid_reg[d] <= 1'b0;
          if (tick && wb_age_reg[d] != dps_pkg::SINCE_MAX) wb_age_reg[d] <= wb_age_reg[d] + 8'h01;
        end
      end
    end
  end

  // column history for three-packet spacing
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hist1_reg <= '0;
      hist2_reg <= '0;
    end else if (col_go) begin
      hist2_reg <= hist1_reg;
      hist1_reg.cls <= o_cls;
      hist1_reg.dev <= col_out.dev;
      hist1_reg.bank <= col_out.bank;
      hist1_reg.unretired <= wb_valid_reg[col_out.dev];
    end
  end

  // pins are registered; a packet stands for one CLK cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      row_pkt_reg <= '0;
      row_pkt_valid_reg <= 1'b0;
      last_row_reg <= '0;
      col_pkt_reg <= '0;
      col_pkt_valid_reg <= 1'b0;
    end else begin
      row_pkt_valid_reg <= row_go;
      col_pkt_valid_reg <= col_go;
      if (row_go) begin
        row_pkt_reg <= ROW_REQ;
        last_row_reg <= ROW_REQ;
      end
      if (col_go) col_pkt_reg <= col_out;
    end
  end
  assign ROW_PKT = row_pkt_reg;
  assign ROW_PKT_VALID = row_pkt_valid_reg;
  assign COL_PKT = col_pkt_reg;
  assign COL_PKT_VALID = col_pkt_valid_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  property p_col_open;
    col_go && o_cls != dps_pkg::cls_idle |-> open_reg[{col_out.dev, col_out.bank}];
  endproperty
  a_col_open: assert property (p_col_open) else $error("column to closed bank");
  property p_col_adj;
    col_go && o_cls != dps_pkg::cls_idle |-> !adj_open(col_out.dev, col_out.bank);
  endproperty
  a_col_adj: assert property (p_col_adj) else $error("column beside open bank");
  property p_col_base;
    col_go |-> col_since >= dps_pkg::COLUMN_PACKET_SPACING;
  endproperty
  a_col_base: assert property (p_col_base) else $error("column packets too close");
  property p_rd_st;
    col_go && hist1_reg.cls == dps_pkg::cls_read && o_cls == dps_pkg::cls_store
      |-> col_since >= dps_pkg::READ_TO_STORE_GAP;
  endproperty
  a_rd_st: assert property (p_rd_st) else $error("store too soon after read");
  property p_st_st_rd;
    col_go && o_cls == dps_pkg::cls_read && hist1_reg.cls == dps_pkg::cls_store &&
      hist2_reg.cls == dps_pkg::cls_store && hist1_reg.dev == col_out.dev &&
      hist2_reg.dev == col_out.dev |-> col_since >= dps_pkg::STORE_TO_RETIRE_DELAY;
  endproperty
  a_st_st_rd: assert property (p_st_st_rd) else $error("read before retire");
  property p_open_col;
    row_go && r_open ##1 (col_go && o_cls != dps_pkg::cls_idle &&
      {col_out.dev, col_out.bank} == $past(ridx)) |-> 1'b0;
  endproperty
  a_open_col: assert property (p_open_col) else $error("column right after open");
  property p_reopen;
    row_go && r_open |-> !open_reg[ridx];
  endproperty
  a_reopen: assert property (p_reopen) else $error("open of open bank");
  property p_row_adj;
    row_go && (r_open || r_close) |-> !adj_open(ROW_REQ.dev, ROW_REQ.bank);
  endproperty
  a_row_adj: assert property (p_row_adj) else $error("neighbour of open bank touched");
  property p_close_wb;
    row_go && r_close |-> !wb_hold;
  endproperty
  a_close_wb: assert property (p_close_wb) else $error("close over unretired store");
  property p_row_space;
    ROW_PKT_VALID |-> row_since == 8'h01 ##0 $past(row_since) >= dps_pkg::ROW_PACKET_LENGTH;
  endproperty
  a_row_space: assert property (p_row_space) else $error("row packets too close");
  property p_read_close;
    row_go && r_close && hist1_reg.cls == dps_pkg::cls_read &&
      {hist1_reg.dev, hist1_reg.bank} == ridx |-> col_since >= dps_pkg::READ_TO_CLOSE_DELAY;
  endproperty
  a_read_close: assert property (p_read_close) else $error("close soon after read");

  c_open_read: cover property (row_go && r_open ##[1:40] col_go && o_cls == dps_pkg::cls_read);
  c_fill: cover property (fill_go);
  c_refused: cover property (ROW_REFUSED || COL_REFUSED);
  c_st_st_rd: cover property (col_go && need_gap(hist2_reg, hist1_reg, o_cls, col_out.dev)
                              == dps_pkg::STORE_TO_RETIRE_DELAY);
endmodule

//--- verif/dps_dev_model.sv
// device model: tracks bank state and counts spacing violations seen on the pins
// assumes one channel cycle per CLK, so gaps are counted in CLK cycles
`timescale 1ns/1ps
module dps_dev_model (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // device pins
  input wire dps_pkg::dps_row_pkt_t ROW_PKT,
  input wire logic ROW_PKT_VALID,
  input wire dps_pkg::dps_col_pkt_t COL_PKT,
  input wire logic COL_PKT_VALID,
  // violations seen
  output int errs
);
  bit open_q [4][16];
  int t_open [4][16];
  int t_close [4][16];
  int cyc, t_col, rd, rb, cd, cb;
  bit rd_q, rd_n, st_n;
  function automatic bit nbr(int d, int b);
    nbr = (b > 0 && open_q[d][b-1]) || (b < 15 && open_q[d][b+1]);
  endfunction
  // neighbours share sense amps, so they share open and close timing too
  task automatic stamp(int d, int b, bit op);
    for (int k = b - 1; k <= b + 1; k++) begin
      if (k >= 0 && k < 16) begin
        if (op) t_open[d][k] = cyc;
        else t_close[d][k] = cyc;
      end
    end
  endtask
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      open_q = '{default: 0};
      t_open = '{default: -99};
      t_close = '{default: -99};
      cyc = 0;
      t_col = -99;
      rd_q = 0;
      errs = 0;
    end else begin
      cyc++;
      rd = ROW_PKT.dev;
      rb = ROW_PKT.bank;
      cd = COL_PKT.dev;
      cb = COL_PKT.bank;
      if (ROW_PKT_VALID &&
          ROW_PKT.op inside {dps_pkg::row_open_cmd, dps_pkg::refresh_open_cmd}) begin
        if (open_q[rd][rb] || nbr(rd, rb) || cyc - t_open[rd][rb] < dps_pkg::OPEN_TO_OPEN_MIN ||
            cyc - t_close[rd][rb] < dps_pkg::CLOSE_TO_OPEN_MIN) errs++;
        open_q[rd][rb] = 1;
        stamp(rd, rb, 1);
      end else if (ROW_PKT_VALID && ROW_PKT.op != dps_pkg::row_idle_cmd) begin
        if (nbr(rd, rb) || (open_q[rd][rb] &&
            cyc - t_open[rd][rb] < dps_pkg::OPEN_TO_CLOSE_MIN)) errs++;
        open_q[rd][rb] = 0;
        stamp(rd, rb, 0);
      end
      if (COL_PKT_VALID) begin
        rd_n = COL_PKT.op inside {dps_pkg::column_read_cmd, dps_pkg::read_then_close_cmd};
        st_n = COL_PKT.op inside {dps_pkg::column_store_cmd, dps_pkg::store_then_close_cmd};
        if ((rd_n || st_n) && (!open_q[cd][cb] ||
            cyc - t_open[cd][cb] < dps_pkg::OPEN_TO_COLUMN_DELAY)) errs++;
        if (cyc - t_col < (rd_q && st_n ? dps_pkg::READ_TO_STORE_GAP :
            dps_pkg::COLUMN_PACKET_SPACING)) errs++;
        if (COL_PKT.op inside {dps_pkg::column_close_cmd, dps_pkg::read_then_close_cmd,
            dps_pkg::store_then_close_cmd}) begin
          open_q[cd][cb] = 0;
          stamp(cd, cb, 0);
        end
        t_col = cyc;
        rd_q = rd_n;
      end
    end
  end
endmodule

//--- verif/dps_row_col_sched_test.sv
// testbench for the packet spacing scheduler with a device model on its pins
// assumes one channel cycle per CLK; gaps are measured between packet pulses
`timescale 1ns/1ps
module dps_row_col_sched_test;
  logic clk, arst_n, row_req_valid, col_req_valid, row_req_ready, col_req_ready;
  logic row_refused, col_refused, row_pkt_valid, col_pkt_valid;
  dps_pkg::dps_row_pkt_t row_req, row_pkt;
  dps_pkg::dps_col_pkt_t col_req, col_pkt;
  int failures, checked, dev_errs, cyc, t_row, t_col, t_o, t;
  dps_row_col_sched #(.TICK_DIV(8'h01)) i_dps_row_col_sched (.CLK(clk), .ARST_N(arst_n),
    .ROW_REQ(row_req), .ROW_REQ_VALID(row_req_valid), .ROW_REQ_READY(row_req_ready),
    .ROW_REFUSED(row_refused), .COL_REQ(col_req), .COL_REQ_VALID(col_req_valid),
    .COL_REQ_READY(col_req_ready), .COL_REFUSED(col_refused), .ROW_PKT(row_pkt),
    .ROW_PKT_VALID(row_pkt_valid), .COL_PKT(col_pkt), .COL_PKT_VALID(col_pkt_valid));
  dps_dev_model i_dps_dev_model (.CLK(clk), .ARST_N(arst_n), .ROW_PKT(row_pkt),
    .ROW_PKT_VALID(row_pkt_valid), .COL_PKT(col_pkt), .COL_PKT_VALID(col_pkt_valid),
    .errs(dev_errs));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (row_pkt_valid === 1'b1) t_row = cyc;
    if (col_pkt_valid === 1'b1) t_col = cyc;
  end
  task automatic chk(string what, int lo, int got);
    checked++;
    if (got < lo) begin
      failures++;
      $display("[FAIL] %s expected at least %0d seen %0d", what, lo, got);
    end
  endtask
  // one request held until taken; a refused one must leave no packet behind
  task automatic req(bit c, logic [8:0] p, bit refuse);
    int n;
    int t0;
    n = 0;
    @(posedge clk);
    if (c) col_req <= dps_pkg::dps_col_pkt_t'(p);
    else row_req <= dps_pkg::dps_row_pkt_t'(p);
    if (c) col_req_valid <= 1'b1;
    else row_req_valid <= 1'b1;
    @(negedge clk);
    t0 = c ? t_col : t_row;
    while ((c ? col_req_ready : row_req_ready) !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk("ready wait", 0, 399 - n);
    chk("refused flag", 1, (c ? col_refused : row_refused) === refuse);
    @(posedge clk);
    if (c) col_req_valid <= 1'b0;
    else row_req_valid <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("packet issued", 1, (c ? (t_col != t0 && col_pkt === col_req) :
      (t_row != t0 && row_pkt === row_req)) == !refuse);
  endtask
  task automatic sc_open_read();
    req(0, {dps_pkg::row_open_cmd, 2'h0, 4'h5}, 0);
    t_o = t_row;
    req(1, {dps_pkg::column_read_cmd, 2'h0, 4'h5}, 0);
    chk("open to read gap", dps_pkg::OPEN_TO_COLUMN_DELAY, t_col - t_row);
  endtask
  task automatic sc_refuse();
    req(1, {dps_pkg::column_read_cmd, 2'h0, 4'h4}, 1);
    req(0, {dps_pkg::row_open_cmd, 2'h0, 4'h5}, 1);
    req(0, {dps_pkg::row_close_cmd, 2'h0, 4'h6}, 1);
    req(1, {dps_pkg::column_store_cmd, 2'h1, 4'h3}, 1);
  endtask
  task automatic sc_store_close();
    req(1, {dps_pkg::column_read_cmd, 2'h0, 4'h5}, 0);
    t = t_col;
    req(1, {dps_pkg::column_store_cmd, 2'h0, 4'h5}, 0);
    chk("read to store gap", dps_pkg::READ_TO_STORE_GAP, t_col - t);
    t = t_col;
    req(0, {dps_pkg::row_close_cmd, 2'h0, 4'h5}, 0);
    chk("store to close gap", dps_pkg::STORE_TO_RETIRE_DELAY + dps_pkg::RETIRE_TO_CLOSE_DELAY,
      t_row - t);
    chk("retire idle", 1, col_pkt === {dps_pkg::column_idle_cmd, 6'h00});
    chk("open to close gap", dps_pkg::OPEN_TO_CLOSE_MIN, t_row - t_o);
    t = t_row;
    req(0, {dps_pkg::row_open_cmd, 2'h0, 4'h6}, 0);
    chk("close to open gap", dps_pkg::CLOSE_TO_OPEN_MIN, t_row - t);
    chk("open to open gap", dps_pkg::OPEN_TO_OPEN_MIN, t_row - t_o);
    req(1, {dps_pkg::column_store_cmd, 2'h0, 4'h6}, 0);
    req(1, {dps_pkg::column_store_cmd, 2'h0, 4'h6}, 0);
    t = t_col;
    req(1, {dps_pkg::column_read_cmd, 2'h0, 4'h6}, 0);
    chk("store store read gap", dps_pkg::STORE_TO_RETIRE_DELAY, t_col - t);
  endtask
  task automatic sc_closing();
    dps_pkg::dps_col_op_t ops [3] = '{dps_pkg::column_close_cmd, dps_pkg::read_then_close_cmd,
      dps_pkg::store_then_close_cmd};
    logic [3:0] bk [3] = '{4'h1, 4'h3, 4'h5};
    for (int k = 0; k < 3; k++) begin
      req(0, {dps_pkg::refresh_open_cmd, 2'h3, bk[k]}, 0);
      req(1, {ops[k], 2'h3, bk[k]}, 0);
      req(1, {dps_pkg::column_read_cmd, 2'h3, bk[k]}, 1);
    end
    req(0, {dps_pkg::refresh_open_cmd, 2'h3, 4'h9}, 0);
    t = t_row;
    req(0, {dps_pkg::refresh_close_cmd, 2'h3, 4'h9}, 0);
    chk("refresh open to close gap", dps_pkg::OPEN_TO_CLOSE_MIN, t_row - t);
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    failures++;
    give_verdict();
  end
  initial begin
    {arst_n, row_req_valid, col_req_valid, row_req, col_req} = '0;
    {failures, checked, cyc, t_row, t_col, t_o, t} = '0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    sc_open_read();
    sc_refuse();
    sc_store_close();
    sc_closing();
    chk("device model clean", 1, dev_errs == 0);
    give_verdict();
  end
endmodule
